// [eprom_prog_host.v]
// Host controller driving a byte-wide UV memory through its pins:
// reads, id reads, and a full pulse/verify programming pass.
// Assumes external level switches for the program voltage and the high id level.
//
// Overview of operation
// - Program needs voltage, strobe low, gate high
// - Programmer drives full byte in parallel
// - Fixed pulses, only as many as needed
// - Verify after each pulse until match/limit
// - Every address in turn, then full verify
// - Verify: gate low, strobe high, voltage on
// - Id mode by high level on trigger
// - Id mode: other address lines held low
// - Address stable before expecting data
`timescale 1ns/1ps
`default_nettype none
`include "eprom_prog_defs.vh"
module eprom_prog_host
(
	input  wire        sys_clk_in,
	input  wire        nrst_in,
	input  wire        rd_req_in,
	input  wire        id_req_in,
	input  wire        prog_req_in,
	input  wire [18:0] req_addr_in,
	input  wire [7:0]  prog_data_in,
	input  wire [18:0] prog_last_in,
	input  wire [7:0]  byte_data_lines_in,
	output reg  [7:0]  byte_data_lines_out,
	output reg         byte_data_lines_oe_out,
	output reg  [18:0] byte_address_lines_out,
	output reg         select_program_strobe_n_out,
	output reg         output_gate_n_out,
	output reg         program_voltage_on_out,
	output reg         id_trigger_high_out,
	output reg         busy_out,
	output reg         done_out,
	output reg  [7:0]  rd_data_out,
	output reg         fail_out,
	output reg         id_parity_ok_out
);
	localparam S_IDLE  = 9'b0_0000_0001;
	localparam S_READ  = 9'b0_0000_0010;
	localparam S_SETUP = 9'b0_0000_0100;
	localparam S_PULSE = 9'b0_0000_1000;
	localparam S_RECOV = 9'b0_0001_0000;
	localparam S_VRFY  = 9'b0_0010_0000;
	localparam S_FINAL = 9'b0_0100_0000;
	localparam S_FREAD = 9'b0_1000_0000;
	localparam S_END   = 9'b1_0000_0000;

	reg        rst_m_ff, rst_s_ff;
	wire       rst_n = rst_s_ff;
	reg  [8:0] st_ff;
	reg  [15:0] cnt_ff;
	reg  [7:0] pulses_ff;
	reg  [7:0] din_m_ff, din_s_ff, din_t_ff;
	wire       din_stable = (din_s_ff == din_t_ff);

	// Reset release is synchronised; assertion stays asynchronous
	always @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			rst_m_ff <= 1'b0;
			rst_s_ff <= 1'b0;
		end
		else
		begin
			rst_m_ff <= 1'b1;
			rst_s_ff <= rst_m_ff;
		end
	end

	// Pin inputs: value counts once stages two and three agree
	always @(posedge sys_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			din_m_ff <= 8'h00;
			din_s_ff <= 8'h00;
			din_t_ff <= 8'h00;
		end
		else
		begin
			din_m_ff <= byte_data_lines_in;
			din_s_ff <= din_m_ff;
			din_t_ff <= din_s_ff;
		end
	end

	always @(posedge sys_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_ff                       <= S_IDLE;
			cnt_ff                      <= 16'h0000;
			pulses_ff                   <= 8'h00;
			byte_data_lines_out         <= 8'h00;
			byte_data_lines_oe_out      <= 1'b0;
			byte_address_lines_out      <= 19'h0_0000;
			select_program_strobe_n_out <= 1'b1;
			output_gate_n_out           <= 1'b1;
			program_voltage_on_out      <= 1'b0;
			id_trigger_high_out         <= 1'b0;
			busy_out                    <= 1'b0;
			done_out                    <= 1'b0;
			rd_data_out                 <= 8'h00;
			fail_out                    <= 1'b0;
			id_parity_ok_out            <= 1'b0;
		end
		else
		begin
			done_out <= 1'b0;
			case (st_ff)
			S_IDLE:
			begin
				// Idle is standby: strobe high floats the device outputs
				select_program_strobe_n_out <= 1'b1;
				output_gate_n_out           <= 1'b1;
				byte_data_lines_oe_out      <= 1'b0;
				program_voltage_on_out      <= 1'b0;
				id_trigger_high_out         <= 1'b0;
				cnt_ff                      <= 16'h0000;
				if (prog_req_in)
				begin
					busy_out               <= 1'b1;
					fail_out               <= 1'b0;
					byte_address_lines_out <= 19'h0_0000;
					program_voltage_on_out <= 1'b1;
					pulses_ff              <= 8'h00;
					st_ff                  <= S_SETUP;
				end
				else if (rd_req_in || id_req_in)
				begin
					busy_out                    <= 1'b1;
					select_program_strobe_n_out <= 1'b0;
					output_gate_n_out           <= 1'b0;
					if (rd_req_in)
					begin
						byte_address_lines_out <= req_addr_in;
					end
					else
					begin
						// Only the byte-select bit may be nonzero in id mode
						id_trigger_high_out    <= 1'b1;
						byte_address_lines_out <= {18'h0_0000, req_addr_in[0]};
					end
					st_ff <= S_READ;
				end
			end
			S_READ:
			begin
				// Address held steady over the whole wait plus input sync
				cnt_ff <= cnt_ff + 16'h0001;
				if (cnt_ff >= `ACCESS_CYC && din_stable)
				begin
					rd_data_out                 <= din_t_ff;
					id_parity_ok_out            <= ^din_t_ff;
					select_program_strobe_n_out <= 1'b1;
					output_gate_n_out           <= 1'b1;
					id_trigger_high_out         <= 1'b0;
					busy_out                    <= 1'b0;
					done_out                    <= 1'b1;
					st_ff                       <= S_IDLE;
				end
			end
			S_SETUP:
			begin
				// Gate high and the full byte on the lines before the strobe falls
				output_gate_n_out      <= 1'b1;
				byte_data_lines_out    <= prog_data_in;
				byte_data_lines_oe_out <= 1'b1;
				cnt_ff                 <= cnt_ff + 16'h0001;
				if (cnt_ff >= `SETUP_CYC)
				begin
					cnt_ff                      <= 16'h0000;
					select_program_strobe_n_out <= 1'b0;
					pulses_ff                   <= pulses_ff + 8'h01;
					st_ff                       <= S_PULSE;
				end
			end
			S_PULSE:
			begin
				cnt_ff <= cnt_ff + 16'h0001;
				if (cnt_ff >= `PULSE_CYC - 1)
				begin
					cnt_ff                      <= 16'h0000;
					select_program_strobe_n_out <= 1'b1;
					st_ff                       <= S_RECOV;
				end
			end
			S_RECOV:
			begin
				// Release data before the gate opens to avoid contention
				byte_data_lines_oe_out <= 1'b0;
				cnt_ff                 <= cnt_ff + 16'h0001;
				if (cnt_ff >= `SETUP_CYC)
				begin
					cnt_ff            <= 16'h0000;
					output_gate_n_out <= 1'b0;
					st_ff             <= S_VRFY;
				end
			end
			S_VRFY:
			begin
				cnt_ff <= cnt_ff + 16'h0001;
				if (cnt_ff >= `ACCESS_CYC && din_stable)
				begin
					cnt_ff            <= 16'h0000;
					output_gate_n_out <= 1'b1;
					if (din_t_ff == prog_data_in)
					begin
						pulses_ff <= 8'h00;
						if (byte_address_lines_out == prog_last_in)
						begin
							program_voltage_on_out <= 1'b0;
							byte_address_lines_out <= 19'h0_0000;
							st_ff                  <= S_FINAL;
						end
						else
						begin
							byte_address_lines_out <= byte_address_lines_out + 19'h0_0001;
							st_ff                  <= S_SETUP;
						end
					end
					else if (pulses_ff >= `MAX_PULSES)
					begin
						fail_out <= 1'b1;
						st_ff    <= S_END;
					end
					else
					begin
						st_ff <= S_SETUP;
					end
				end
			end
			S_FINAL:
			begin
				// Final pass is a plain read with the voltage removed
				select_program_strobe_n_out <= 1'b0;
				output_gate_n_out           <= 1'b0;
				cnt_ff                      <= 16'h0000;
				st_ff                       <= S_FREAD;
			end
			S_FREAD:
			begin
				cnt_ff <= cnt_ff + 16'h0001;
				if (cnt_ff >= `ACCESS_CYC && din_stable)
				begin
					cnt_ff <= 16'h0000;
					// Each byte up to prog_last_in must read back as prog_data_in
					if (din_t_ff != prog_data_in)
					begin
						fail_out <= 1'b1;
						st_ff    <= S_END;
					end
					else if (byte_address_lines_out == prog_last_in)
					begin
						st_ff <= S_END;
					end
					else
					begin
						byte_address_lines_out <= byte_address_lines_out + 19'h0_0001;
					end
				end
			end
			S_END:
			begin
				select_program_strobe_n_out <= 1'b1;
				output_gate_n_out           <= 1'b1;
				byte_data_lines_oe_out      <= 1'b0;
				program_voltage_on_out      <= 1'b0;
				busy_out                    <= 1'b0;
				done_out                    <= 1'b1;
				st_ff                       <= S_IDLE;
			end
			default:
			begin
				st_ff <= S_IDLE;
			end
			endcase
		end
	end
endmodule // eprom_prog_host
`default_nettype wire

// [eprom_prog_defs.vh]
// Timing and code constants for the byte-wide UV memory programmer/reader.
// Assumes a 40 MHz system clock; analog levels are selected by external switches.
`ifndef EPROM_PROG_DEFS_VH
`define EPROM_PROG_DEFS_VH
`define CLK_MHZ            40
`define ADDR_W             19
`define LAST_ADDR          19'h7_FFFF
`define ERASED_BYTE        8'hFF
`define PULSE_US           100
`define PULSE_CYC          (`PULSE_US * `CLK_MHZ)
`define MAX_PULSES         8'h19
`define ACCESS_NS          200
`define ACCESS_CYC         ((`ACCESS_NS * `CLK_MHZ + 999) / 1000)
`define SETUP_NS           2000
`define SETUP_CYC          ((`SETUP_NS * `CLK_MHZ + 999) / 1000)
`define ID_MFR_SEL         1'b0
`define ID_DEV_SEL         1'b1
`endif

// [eprom_dev_model.sv]
// Behavioural model of the byte-wide UV memory seen from its pins.
// Assumes the bench resolves the shared data lines; only 16 bytes are kept (address aliases).
`timescale 1ns/1ps
`default_nettype none
module eprom_dev_model
#(
	parameter logic [7:0] MFR = 8'h07, // Arbitrary value, odd parity
	parameter logic [7:0] DEV = 8'hC8  // Arbitrary value, odd parity
)
(
	input  wire logic [18:0] addr_in,
	input  wire logic [7:0]  data_in,
	input  wire logic        strobe_n_in,
	input  wire logic        gate_n_in,
	input  wire logic        pgm_volt_in,
	input  wire logic        idhi_in,
	output wire logic [7:0]  data_out
);
	logic [7:0] mem [0:15];
	logic [7:0] pulses [0:15];
	logic [7:0] din;
	logic [3:0] k;
	wire        drv = !gate_n_in && (!strobe_n_in || pgm_volt_in);
	wire [7:0]  val = idhi_in ? (addr_in[0] ? DEV : MFR) : mem[addr_in[3:0]];
	// Undriven lines show the inverse so a stale sample never matches
	assign #150 data_out = drv ? val : ~val;
	initial
	begin
		for (int i = 0; i < 16; i++)
		begin
			mem[i] = 8'hFF;
			pulses[i] = 8'h00;
		end
	end
	always @(negedge strobe_n_in)
	begin
		din = data_in;
		k = addr_in[3:0];
	end
	// Byte 1 is slow and needs a second pulse
	always @(posedge strobe_n_in)
		if (pgm_volt_in && gate_n_in)
		begin
			pulses[k] = pulses[k] + 8'h01;
			if (pulses[k] >= ((k == 4'h1) ? 8'h02 : 8'h01))
				mem[k] = mem[k] & din;
		end
endmodule // eprom_dev_model
`default_nettype wire

// [eprom_prog_host_monitor.sv]
// Checker for the pin-side outputs of the memory host controller.
// Assumes it is bound onto eprom_prog_host and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module eprom_prog_host_monitor
(
	input wire logic        sys_clk_in,
	input wire logic        nrst_in,
	input wire logic [7:0]  byte_data_lines_out,
	input wire logic        byte_data_lines_oe_out,
	input wire logic [18:0] byte_address_lines_out,
	input wire logic        select_program_strobe_n_out,
	input wire logic        output_gate_n_out,
	input wire logic        program_voltage_on_out,
	input wire logic        id_trigger_high_out
);
	wire        s = select_program_strobe_n_out;
	wire        g = output_gate_n_out;
	wire        v = program_voltage_on_out;
	wire [18:0] a = byte_address_lines_out;
	logic [12:0] len_ff;
	always @(posedge sys_clk_in or negedge nrst_in)
		if (!nrst_in)
			len_ff <= 13'h0000;
		else
			len_ff <= (s || !v) ? 13'h0000 : len_ff + 13'h0001;
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);
	property p_prog_gate; v && !s |-> g; endproperty
	a_prog_gate: assert property (p_prog_gate) else $error("pulse with gate low");
	property p_prog_data; v && !s |-> byte_data_lines_oe_out; endproperty
	a_prog_data: assert property (p_prog_data) else $error("pulse without data");
	property p_pulse_len; v && $rose(s) |-> len_ff == 13'h0FA0; endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
	property p_pulse_hold; v && !s && $past(v && !s) |-> $stable(a) && $stable(byte_data_lines_out);
	endproperty
	a_pulse_hold: assert property (p_pulse_hold) else $error("moved in pulse");
	property p_verify; v && $rose(s) |-> ##[1:200] (s && !g); endproperty
	a_verify: assert property (p_verify) else $error("no verify");
	property p_verify_oe; !g |-> !byte_data_lines_oe_out; endproperty
	a_verify_oe: assert property (p_verify_oe) else $error("contention");
	property p_id_addr; id_trigger_high_out |-> a[18:1] == 18'h0_0000; endproperty
	a_id_addr: assert property (p_id_addr) else $error("id address");
	property p_vpp_entry; $rose(v) |-> s && g; endproperty
	a_vpp_entry: assert property (p_vpp_entry) else $error("voltage entry");
endmodule // eprom_prog_host_monitor
bind eprom_prog_host eprom_prog_host_monitor mon (.sys_clk_in, .nrst_in, .byte_data_lines_out,
	.byte_data_lines_oe_out, .byte_address_lines_out, .select_program_strobe_n_out,
	.output_gate_n_out, .program_voltage_on_out, .id_trigger_high_out);
`default_nettype wire

// [eprom_prog_host_tb.sv]
// Self-checking bench for the memory host controller.
// Assumes eprom_dev_model stands on the pins; a 4-byte pass keeps the run short.
`timescale 1ns/1ps
`default_nettype none
module eprom_prog_host_tb;
	localparam logic [7:0] MFR = 8'h07; // Arbitrary id value, odd parity
	localparam logic [7:0] DEV = 8'hC8; // Arbitrary id value, odd parity
	logic        sys_clk_in = 0, nrst_in = 0, rd_req_in = 0, id_req_in = 0, prog_req_in = 0;
	logic [18:0] req_addr_in = 0, prog_last_in = 0;
	logic [7:0]  prog_data_in = 0, d;
	integer      fails = 0, samples_checked = 0, seed = 93020, i;
	wire [7:0]   byte_data_lines_in, byte_data_lines_out, rd_data_out, m_lines;
	wire [18:0]  byte_address_lines_out;
	wire         byte_data_lines_oe_out, select_program_strobe_n_out, output_gate_n_out;
	wire         program_voltage_on_out, id_trigger_high_out, busy_out, done_out, fail_out;
	wire         id_parity_ok_out;
	assign byte_data_lines_in = byte_data_lines_oe_out ? byte_data_lines_out : m_lines;
	always #12.5 sys_clk_in = ~sys_clk_in;
	eprom_prog_host dut (.sys_clk_in, .nrst_in, .rd_req_in, .id_req_in, .prog_req_in,
		.req_addr_in, .prog_data_in, .prog_last_in, .byte_data_lines_in, .byte_data_lines_out,
		.byte_data_lines_oe_out, .byte_address_lines_out, .select_program_strobe_n_out,
		.output_gate_n_out, .program_voltage_on_out, .id_trigger_high_out, .busy_out,
		.done_out, .rd_data_out, .fail_out, .id_parity_ok_out);
	eprom_dev_model #(.MFR(MFR), .DEV(DEV)) dev (.addr_in(byte_address_lines_out),
		.data_in(byte_data_lines_in), .strobe_n_in(select_program_strobe_n_out),
		.gate_n_in(output_gate_n_out), .pgm_volt_in(program_voltage_on_out),
		.idhi_in(id_trigger_high_out), .data_out(m_lines));
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task give_verdict;
		if (fails == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// One request held for one edge, then wait for its completion pulse
	task op(input logic [2:0] k, input logic [18:0] a);
		integer n;
		@(negedge sys_clk_in);
		{prog_req_in, rd_req_in, id_req_in} = k;
		req_addr_in = a;
		@(negedge sys_clk_in);
		{prog_req_in, rd_req_in, id_req_in} = 3'h0;
		chk({7'h00, busy_out}, 8'h01);
		n = 0;
		while (done_out !== 1'b1 && n < 40000)
		begin
			@(posedge sys_clk_in);
			#1;
			n++;
		end
		chk({7'h00, busy_out}, 8'h00);
		if (n >= 40000)
			fails++;
	endtask
	function logic [7:0] id_exp(input logic b);
		return b ? DEV : MFR;
	endfunction
	function logic [7:0] after_prog(input logic [18:0] a, input logic [7:0] dd);
		return (a <= prog_last_in) ? dd : 8'hFF;
	endfunction
	initial
	begin
		repeat (12) @(negedge sys_clk_in);
		nrst_in = 1;
		repeat (3) @(negedge sys_clk_in);
		for (i = 0; i < 6; i++)
		begin
			op(3'b010, 19'($random(seed)));
			chk(rd_data_out, 8'hFF);
		end
		for (i = 0; i < 2; i++)
		begin
			op(3'b001, 19'(i));
			chk(rd_data_out, id_exp(i[0]));
			chk({7'h00, id_parity_ok_out}, 8'h01);
		end
		@(negedge sys_clk_in);
		d = 8'($random(seed));
		// All ones would verify after one pulse and hide the slow byte
		if (d == 8'hFF)
			d = 8'h5A;
		prog_data_in = d;
		prog_last_in = 19'h0_0003;
		op(3'b100, 19'h0_0000);
		chk({7'h00, fail_out}, 8'h00);
		for (i = 0; i < 5; i++)
		begin
			chk(dev.pulses[i], (i == 1) ? 8'h02 : (i < 4) ? 8'h01 : 8'h00);
			op(3'b010, 19'(i));
			chk(rd_data_out, after_prog(19'(i), d));
		end
		give_verdict;
	end
	initial
	begin
		#1500000;
		fails++;
		give_verdict;
	end
endmodule // eprom_prog_host_tb
`default_nettype wire
